//--- rtl/sfp_pkg.sv
// Shared constants, types and helpers for the serial flash pin front end
package sfp_pkg;

   // ------------------------------------------------------------------
   // Geometry
   // ------------------------------------------------------------------
   localparam int SFP_LANES      = 4;
   localparam int SFP_BYTE_W     = 8;
   localparam int SFP_FIFO_DEPTH = 16;
   localparam int SFP_PAGE_BYTES = 256;
   localparam int SFP_UID_W      = 64;

   localparam logic [3:0]  SFP_BYTE_BITS  = 4'h8;
   localparam logic [16:0] SFP_ERASE_4K   = 17'h01000;
   localparam logic [16:0] SFP_ERASE_32K  = 17'h08000;
   localparam logic [16:0] SFP_ERASE_64K  = 17'h10000;
   localparam logic [1:0]  SFP_ERASE_SEL_4K  = 2'h0;
   localparam logic [1:0]  SFP_ERASE_SEL_32K = 2'h1;
   localparam logic [1:0]  SFP_ERASE_SEL_64K = 2'h2;
   localparam logic [1:0]  SFP_SEC_AREAS  = 2'h3;
   localparam int          SFP_SEC_AREA_BYTES = 256;

   // ------------------------------------------------------------------
   // Lane masks
   // ------------------------------------------------------------------
   localparam logic [3:0] SFP_MASK_NONE   = 4'h0;
   localparam logic [3:0] SFP_MASK_SINGLE = 4'h2;
   localparam logic [3:0] SFP_MASK_DUAL   = 4'h3;
   localparam logic [3:0] SFP_MASK_QUAD   = 4'hF;

   // ------------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------------
   localparam int SFP_CLK_PERIOD_NS = 25;
   localparam int SFP_HWRST_MIN_NS  = 1000;
   localparam int SFP_HWRST_CYC     =
      (SFP_HWRST_MIN_NS + SFP_CLK_PERIOD_NS - 1) / SFP_CLK_PERIOD_NS;

   // ------------------------------------------------------------------
   // Types
   // ------------------------------------------------------------------
   typedef enum logic [1:0]
   {
      SFP_W_SINGLE = 2'h0,
      SFP_W_DUAL   = 2'h1,
      SFP_W_QUAD   = 2'h3
   } sfp_width_t;

   typedef enum logic [1:0]
   {
      SFP_ST_IDLE      = 2'h0,
      SFP_ST_SHIFT_IN  = 2'h1,
      SFP_ST_SHIFT_OUT = 2'h3
   } sfp_state_t;

   function automatic logic [3:0] sfp_beat_bits(input sfp_width_t w);
      case (w)
         SFP_W_DUAL: sfp_beat_bits = 4'h2;
         SFP_W_QUAD: sfp_beat_bits = 4'h4;
         default:    sfp_beat_bits = 4'h1;
      endcase
   endfunction : sfp_beat_bits

endpackage : sfp_pkg

//--- rtl/sfp_edge.sv
// Rise and fall detector for a pin sampled on the system clock
module sfp_edge
   import sfp_pkg::*;
(
   input  wire logic sys_clk_in,
   input  wire logic rst_in,
   input  wire logic sig_in,
   output logic      rise_out,
   output logic      fall_out
);

   logic prev_r;

   always_ff @(posedge sys_clk_in)
   begin
      if (rst_in)
         prev_r <= sig_in;
      else
         prev_r <= sig_in;
   end

   assign rise_out = sig_in & ~prev_r;
   assign fall_out = ~sig_in & prev_r;

endmodule : sfp_edge

//--- rtl/sfp_fifo.sv
// Flip-flop FIFO with valid/ready on both sides
module sfp_fifo
   import sfp_pkg::*;
#(
   parameter int WIDTH = SFP_BYTE_W,
   parameter int DEPTH = SFP_FIFO_DEPTH
)
(
   input  wire logic             sys_clk_in,
   input  wire logic             rst_in,
   input  wire logic [WIDTH-1:0] in_data_in,
   input  wire logic             in_valid_in,
   output logic                  in_ready_out,
   output logic      [WIDTH-1:0] out_data_out,
   output logic                  out_valid_out,
   input  wire logic             out_ready_in
);

   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
   localparam logic [AW:0]   FULL = (AW + 1)'(DEPTH);

   if (DEPTH < 2 || WIDTH < 1)
   begin : g_bad_param
      $error("sfp_fifo: DEPTH must be at least 2 and WIDTH at least 1");
   end

   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0]    wr_r;
   logic [AW-1:0]    rd_r;
   logic [AW:0]      cnt_r;
   logic [AW:0]      cnt_nxt;
   logic             full_r;
   logic             empty_r;
   logic             push;
   logic             pop;

   assign push    = in_valid_in & ~full_r;
   assign pop     = out_ready_in & ~empty_r;
   assign cnt_nxt = cnt_r + (AW + 1)'(push) - (AW + 1)'(pop);

   always_ff @(posedge sys_clk_in)
   begin
      if (push)
         mem_r[wr_r] <= in_data_in;
   end

   always_ff @(posedge sys_clk_in)
   begin
      if (rst_in)
      begin
         wr_r    <= '0;
         rd_r    <= '0;
         cnt_r   <= '0;
         full_r  <= 1'h0;
         empty_r <= 1'h1;
      end
      else
      begin
         if (push)
            wr_r <= (wr_r == LAST) ? '0 : wr_r + 1'h1;
         if (pop)
            rd_r <= (rd_r == LAST) ? '0 : rd_r + 1'h1;
         cnt_r   <= cnt_nxt;
         full_r  <= (cnt_nxt == FULL);
         empty_r <= (cnt_nxt == '0);
      end
   end

   assign in_ready_out  = ~full_r;
   assign out_valid_out = ~empty_r;
   assign out_data_out  = mem_r[rd_r];

endmodule : sfp_fifo

//--- rtl/sfp_pin_front.sv
// Serial flash pin front end: select, lane sampling and driving, hold, hardware reset
// ------------------------------------------------------------------
// How it works
// - Chip select high: every data lane output enable is off.
// - Chip select low selects the device; bytes are taken and sent.
// - Nothing is taken until chip select has fallen once after reset.
// - Single width: lane zero sampled on each rising serial clock edge.
// - Single width: read bits leave on lane one at falling clock edges.
// - Dual and quad: lanes sampled on rising, driven on falling edges.
// - Quad width acts only while the quad lane enable input is set.
// - With quad lane enable set, protect and hold pins become lanes two, three.
// - Single and dual use lanes zero and one; quad uses all four.
// - Hold works only in single and dual, never as a quad lane.
// - Hardware reset pin resets the block whatever its state.
// - A page program of 1 to 256 bytes is accepted; excess flagged.
// - Erase units of 4, 32 and 64 kilobytes are reported.
// - A running erase or program can be suspended and resumed.
// - Three security areas of 256 bytes each are recognised.
// - A 64-bit unique identifier is held and readable.
// - Standby only when deselected and no internal cycle runs.
// - Hold low while selected: lanes released, clock and data ignored.
// - Clock may idle low or high; only edges inside selection count.
// ------------------------------------------------------------------
module sfp_pin_front
   import sfp_pkg::*;
#(
   parameter int                   FIFO_DEPTH   = SFP_FIFO_DEPTH,
   parameter int                   HWRST_CYCLES = SFP_HWRST_CYC,
   // Arbitrary value, replace per device
   parameter logic [SFP_UID_W-1:0] UNIQUE_ID    = 64'h5A5A_0000_1234_C3C3
)
(
   input  wire logic                  sys_clk_in,
   input  wire logic                  rst_in,
   input  wire logic                  hw_reset_n_in,
   input  wire logic                  cs_n_in,
   input  wire logic                  sclk_in,
   input  wire logic [SFP_LANES-1:0]  lane_in,
   output logic      [SFP_LANES-1:0]  lane_out,
   output logic      [SFP_LANES-1:0]  lane_oe_out,
   input  wire logic                  quad_lane_enable_in,
   input  sfp_width_t                 width_in,
   input  wire logic                  out_start_in,
   input  wire logic [SFP_BYTE_W-1:0] tx_data_in,
   input  wire logic                  tx_valid_in,
   output logic                       tx_ready_out,
   output logic      [SFP_BYTE_W-1:0] rx_data_out,
   output logic                       rx_valid_out,
   input  wire logic                  rx_ready_in,
   input  wire logic                  busy_in,
   input  wire logic                  suspend_req_in,
   input  wire logic                  resume_req_in,
   input  wire logic [1:0]            erase_sel_in,
   input  wire logic [1:0]            sec_area_in,
   output logic                       selected_out,
   output logic                       standby_out,
   output logic                       armed_out,
   output logic                       hold_out,
   output logic                       quad_refused_out,
   output logic                       overrun_out,
   output logic                       page_over_out,
   output logic                       suspended_out,
   output logic      [16:0]           erase_bytes_out,
   output logic                       sec_area_ok_out,
   output logic      [SFP_UID_W-1:0]  unique_id_out
);

   localparam int HWCW = $clog2(HWRST_CYCLES + 1);
   localparam int PGW  = $clog2(SFP_PAGE_BYTES + 1);
   localparam logic [HWCW-1:0] HWRST_LAST = HWCW'(HWRST_CYCLES);
   localparam logic [PGW-1:0]  PAGE_LAST  = PGW'(SFP_PAGE_BYTES);

   if (HWRST_CYCLES < 1 || FIFO_DEPTH < 2)
   begin : g_bad_param
      $error("sfp_pin_front: HWRST_CYCLES must be >= 1 and FIFO_DEPTH >= 2");
   end

   // ------------------------------------------------------------------
   // Pin edges and hardware reset
   // ------------------------------------------------------------------
   logic sclk_rise;
   logic sclk_fall;
   logic cs_fall;

   sfp_edge u_sclk_edge
   (
      .sys_clk_in (sys_clk_in),
      .rst_in     (rst_in),
      .sig_in     (sclk_in),
      .rise_out   (sclk_rise),
      .fall_out   (sclk_fall)
   );

   sfp_edge u_cs_edge
   (
      .sys_clk_in (sys_clk_in),
      .rst_in     (rst_in),
      .sig_in     (cs_n_in),
      .rise_out   (),
      .fall_out   (cs_fall)
   );

   logic [HWCW-1:0] hwrst_cnt_r;
   logic            core_rst;

   // Short glitches on the reset pin are filtered; a held pin wins over everything
   always_ff @(posedge sys_clk_in)
   begin
      if (rst_in || hw_reset_n_in)
         hwrst_cnt_r <= '0;
      else if (hwrst_cnt_r != HWRST_LAST)
         hwrst_cnt_r <= hwrst_cnt_r + 1'h1;
   end

   assign core_rst = rst_in | (hwrst_cnt_r == HWRST_LAST);

   // ------------------------------------------------------------------
   // Selection, hold and width qualification
   // ------------------------------------------------------------------
   sfp_state_t state_r;
   logic       armed_r;
   logic       sel;
   logic       quad_req;
   logic       hold_ok;
   logic       hold_act;
   logic       refused;
   logic       act;
   logic [3:0] beat;

   always_ff @(posedge sys_clk_in)
   begin
      if (core_rst)
         armed_r <= 1'h0;
      else if (cs_fall)
         armed_r <= 1'h1;
   end

   assign sel      = armed_r & ~cs_n_in;
   assign quad_req = (width_in == SFP_W_QUAD);
   assign hold_ok  = ~quad_lane_enable_in & ~quad_req;
   assign hold_act = sel & hold_ok & ~lane_in[3];
   assign refused  = quad_req & ~quad_lane_enable_in;
   // Serial clock edges count only while selected, so either idle level works
   assign act      = sel & ~hold_act & ~refused;
   assign beat     = sfp_beat_bits(width_in);

   always_ff @(posedge sys_clk_in)
   begin
      if (core_rst)
         state_r <= SFP_ST_IDLE;
      else
         case (state_r)
            SFP_ST_IDLE:
               if (sel)
                  state_r <= SFP_ST_SHIFT_IN;
            SFP_ST_SHIFT_IN:
               if (cs_n_in)
                  state_r <= SFP_ST_IDLE;
               else if (out_start_in)
                  state_r <= SFP_ST_SHIFT_OUT;
            SFP_ST_SHIFT_OUT:
               if (cs_n_in)
                  state_r <= SFP_ST_IDLE;
            default:
               state_r <= SFP_ST_IDLE;
         endcase
   end

   // ------------------------------------------------------------------
   // Inbound shifting and receive FIFO
   // ------------------------------------------------------------------
   logic [SFP_BYTE_W-1:0] rx_sh_r;
   logic [SFP_BYTE_W-1:0] rx_sh_nxt;
   logic [3:0]            rx_bit_r;
   logic [3:0]            bit_sum;
   logic                  rx_take;
   logic                  byte_done;
   logic                  push_r;
   logic [SFP_BYTE_W-1:0] push_data_r;
   logic                  fifo_in_ready;
   logic                  overrun_r;
   logic [PGW-1:0]        page_cnt_r;
   logic                  page_over_r;

   always_comb
   begin
      case (width_in)
         SFP_W_DUAL: rx_sh_nxt = {rx_sh_r[5:0], lane_in[1:0]};
         SFP_W_QUAD: rx_sh_nxt = {rx_sh_r[3:0], lane_in};
         default:    rx_sh_nxt = {rx_sh_r[6:0], lane_in[0]};
      endcase
   end

   assign bit_sum   = rx_bit_r + beat;
   assign byte_done = (bit_sum == SFP_BYTE_BITS);
   assign rx_take   = act & sclk_rise & (state_r == SFP_ST_SHIFT_IN);

   always_ff @(posedge sys_clk_in)
   begin
      if (core_rst || cs_n_in)
      begin
         rx_sh_r  <= '0;
         rx_bit_r <= 4'h0;
      end
      else if (rx_take)
      begin
         rx_sh_r  <= rx_sh_nxt;
         rx_bit_r <= byte_done ? 4'h0 : bit_sum;
      end
   end

   always_ff @(posedge sys_clk_in)
   begin
      if (core_rst)
      begin
         push_r      <= 1'h0;
         push_data_r <= '0;
      end
      else
      begin
         push_r      <= rx_take & byte_done;
         push_data_r <= rx_sh_nxt;
      end
   end

   // The serial link cannot be stalled, so a full FIFO loses the byte and says so
   always_ff @(posedge sys_clk_in)
   begin
      if (core_rst)
         overrun_r <= 1'h0;
      else if (push_r && !fifo_in_ready)
         overrun_r <= 1'h1;
      else if (cs_fall)
         overrun_r <= 1'h0;
   end

   always_ff @(posedge sys_clk_in)
   begin
      if (core_rst || cs_fall)
      begin
         page_cnt_r  <= '0;
         page_over_r <= 1'h0;
      end
      else if (push_r)
      begin
         if (page_cnt_r == PAGE_LAST)
            page_over_r <= 1'h1;
         else
            page_cnt_r <= page_cnt_r + 1'h1;
      end
   end

   sfp_fifo #(
      .WIDTH (SFP_BYTE_W),
      .DEPTH (FIFO_DEPTH)
   ) u_rx_fifo
   (
      .sys_clk_in    (sys_clk_in),
      .rst_in        (core_rst),
      .in_data_in    (push_data_r),
      .in_valid_in   (push_r),
      .in_ready_out  (fifo_in_ready),
      .out_data_out  (rx_data_out),
      .out_valid_out (rx_valid_out),
      .out_ready_in  (rx_ready_in)
   );

   // ------------------------------------------------------------------
   // Outbound shifting and lane drive
   // ------------------------------------------------------------------
   logic [SFP_BYTE_W-1:0] tx_hold_r;
   logic                  tx_full_r;
   logic                  tx_full_nxt;
   logic                  tx_ready_r;
   logic [SFP_BYTE_W-1:0] tx_sh_r;
   logic [3:0]            tx_cnt_r;
   logic                  tx_load;
   logic                  tx_shift;
   logic                  drv_r;
   logic [SFP_BYTE_W-1:0] tx_src;
   logic [SFP_BYTE_W-1:0] tx_sh_nxt;
   logic [3:0]            lane_nxt;
   logic [3:0]            mask;
   logic [3:0]            lane_r;
   logic [3:0]            oe_r;
   logic                  out_phase;

   assign out_phase   = act & sclk_fall & (state_r == SFP_ST_SHIFT_OUT);
   assign tx_load     = out_phase & (tx_cnt_r == 4'h0) & tx_full_r;
   assign tx_shift    = out_phase & (tx_cnt_r != 4'h0);
   assign tx_full_nxt = (tx_valid_in & tx_ready_r) | (tx_full_r & ~tx_load);
   assign tx_src      = tx_load ? tx_hold_r : tx_sh_r;

   always_comb
   begin
      case (width_in)
         SFP_W_DUAL:
         begin
            lane_nxt  = {2'h0, tx_src[7:6]};
            tx_sh_nxt = {tx_src[5:0], 2'h0};
            mask      = SFP_MASK_DUAL;
         end
         SFP_W_QUAD:
         begin
            lane_nxt  = tx_src[7:4];
            tx_sh_nxt = {tx_src[3:0], 4'h0};
            mask      = SFP_MASK_QUAD;
         end
         default:
         begin
            lane_nxt  = {2'h0, tx_src[7], 1'h0};
            tx_sh_nxt = {tx_src[6:0], 1'h0};
            mask      = SFP_MASK_SINGLE;
         end
      endcase
   end

   always_ff @(posedge sys_clk_in)
   begin
      if (core_rst)
      begin
         tx_hold_r  <= '0;
         tx_full_r  <= 1'h0;
         tx_ready_r <= 1'h0;
      end
      else
      begin
         if (tx_valid_in && tx_ready_r)
            tx_hold_r <= tx_data_in;
         tx_full_r  <= tx_full_nxt;
         tx_ready_r <= ~tx_full_nxt;
      end
   end

   always_ff @(posedge sys_clk_in)
   begin
      if (core_rst || cs_n_in)
      begin
         tx_sh_r  <= '0;
         tx_cnt_r <= 4'h0;
      end
      else if (tx_load || tx_shift)
      begin
         tx_sh_r  <= tx_sh_nxt;
         tx_cnt_r <= (tx_load ? SFP_BYTE_BITS : tx_cnt_r) - beat;
      end
   end

   // Lanes change only on a falling serial clock edge
   always_ff @(posedge sys_clk_in)
   begin
      if (core_rst)
         lane_r <= 4'h0;
      else if (tx_load || tx_shift)
         lane_r <= lane_nxt;
   end

   // Drive starts at the first loaded beat, leaving the host the turnaround
   always_ff @(posedge sys_clk_in)
   begin
      if (core_rst || cs_n_in || state_r != SFP_ST_SHIFT_OUT)
         drv_r <= 1'h0;
      else if (tx_load)
         drv_r <= 1'h1;
   end

   always_ff @(posedge sys_clk_in)
   begin
      if (core_rst)
         oe_r <= SFP_MASK_NONE;
      else if (act && state_r == SFP_ST_SHIFT_OUT && (drv_r || tx_load))
         oe_r <= mask;
      else
         oe_r <= SFP_MASK_NONE;
   end

   assign lane_out     = lane_r;
   assign lane_oe_out  = oe_r;
   assign tx_ready_out = tx_ready_r;

   // ------------------------------------------------------------------
   // Status outputs
   // ------------------------------------------------------------------
   logic        selected_r;
   logic        standby_r;
   logic        hold_r;
   logic        refused_r;
   logic        suspended_r;
   logic [16:0] erase_bytes_r;
   logic        sec_ok_r;
   logic [SFP_UID_W-1:0] uid_r;

   always_ff @(posedge sys_clk_in)
   begin
      if (core_rst)
      begin
         selected_r <= 1'h0;
         standby_r  <= 1'h0;
         hold_r     <= 1'h0;
         refused_r  <= 1'h0;
      end
      else
      begin
         selected_r <= sel;
         standby_r  <= cs_n_in & ~busy_in;
         hold_r     <= hold_act;
         refused_r  <= sel & refused;
      end
   end

   // Suspend is only meaningful while an internal cycle runs
   always_ff @(posedge sys_clk_in)
   begin
      if (core_rst)
         suspended_r <= 1'h0;
      else if (suspend_req_in && busy_in)
         suspended_r <= 1'h1;
      else if (resume_req_in)
         suspended_r <= 1'h0;
   end

   always_ff @(posedge sys_clk_in)
   begin
      if (core_rst)
      begin
         erase_bytes_r <= '0;
         sec_ok_r      <= 1'h0;
         uid_r         <= UNIQUE_ID;
      end
      else
      begin
         if (erase_sel_in == SFP_ERASE_SEL_4K)
            erase_bytes_r <= SFP_ERASE_4K;
         else if (erase_sel_in == SFP_ERASE_SEL_32K)
            erase_bytes_r <= SFP_ERASE_32K;
         else if (erase_sel_in == SFP_ERASE_SEL_64K)
            erase_bytes_r <= SFP_ERASE_64K;
         else
            erase_bytes_r <= '0;
         sec_ok_r <= (sec_area_in < SFP_SEC_AREAS);
         uid_r    <= UNIQUE_ID;
      end
   end

   assign selected_out     = selected_r;
   assign standby_out      = standby_r;
   assign armed_out        = armed_r;
   assign hold_out         = hold_r;
   assign quad_refused_out = refused_r;
   assign overrun_out      = overrun_r;
   assign page_over_out    = page_over_r;
   assign suspended_out    = suspended_r;
   assign erase_bytes_out  = erase_bytes_r;
   assign sec_area_ok_out  = sec_ok_r;
   assign unique_id_out    = uid_r;

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (rst_in);

   chk_cs_high_release: assert property (cs_n_in |=> lane_oe_out == SFP_MASK_NONE)
      else $error("lanes driven while deselected");
   chk_select_enter: assert property
      (state_r == SFP_ST_IDLE && sel && !core_rst |=> state_r == SFP_ST_SHIFT_IN)
      else $error("selection did not start a transfer");
   chk_arm_gates: assert property (!armed_r |-> state_r == SFP_ST_IDLE && !push_r)
      else $error("activity before first select edge");
   chk_push_on_rise: assert property (push_r |-> $past(sclk_rise) && $past(act))
      else $error("byte completed without a rising clock");
   chk_lane_on_fall: assert property
      (!core_rst && $changed(lane_r) |-> $past(sclk_fall) || $past(core_rst))
      else $error("lane changed away from a falling clock");
   chk_quad_needs_qe: assert property
      (lane_oe_out == SFP_MASK_QUAD |-> $past(quad_lane_enable_in))
      else $error("quad lanes driven without quad enable");
   chk_single_mask: assert property
      (lane_oe_out != SFP_MASK_NONE && $past(width_in) == SFP_W_SINGLE
       |-> lane_oe_out == SFP_MASK_SINGLE)
      else $error("single width drove a lane other than one");
   chk_hold_release: assert property (hold_act |=> lane_oe_out == SFP_MASK_NONE && hold_out)
      else $error("hold did not release the lanes");
   chk_hw_reset: assert property
      (!hw_reset_n_in [*8] ##1 (hwrst_cnt_r == HWRST_LAST) |=> state_r == SFP_ST_IDLE
       && !armed_r)
      else $error("hardware reset did not return to idle");
   chk_standby_busy: assert property (busy_in |=> !standby_out)
      else $error("standby while an internal cycle runs");

   cov_dual_read: cover property (lane_oe_out == SFP_MASK_DUAL ##1 lane_oe_out == SFP_MASK_DUAL);
   cov_quad_read: cover property (lane_oe_out == SFP_MASK_QUAD);
   cov_hold: cover property (state_r == SFP_ST_SHIFT_IN && hold_act);
   cov_byte_in: cover property (push_r && fifo_in_ready);

endmodule : sfp_pin_front

//--- tb/sfp_host.sv
// SPI host model that drives chip select, serial clock and lanes
module sfp_host
   import sfp_pkg::*;
(
   input  wire logic                 sys_clk_in,
   output logic                      cs_n_out,
   output logic                      sclk_out,
   output logic      [SFP_LANES-1:0] lane_out
);
   timeunit 1ns;
   timeprecision 100ps;
   initial
   begin
      cs_n_out = 1'b0;
      sclk_out = 1'b0;
      lane_out = 4'h9;
   end
   // Mode 3: beat leaves the clock high, so it idles high at both chip select edges
   task automatic sel(input logic en);
      @(negedge sys_clk_in) cs_n_out <= ~en;
      repeat (2) @(negedge sys_clk_in);
   endtask : sel
   // Each clock level lasts two system cycles so the sampler sees it
   task automatic beat(input logic b);
      @(negedge sys_clk_in) sclk_out <= 1'b0;
      lane_out <= {1'b1, 1'b0, ~b, b};
      @(negedge sys_clk_in);
      @(negedge sys_clk_in) sclk_out <= 1'b1;
      @(negedge sys_clk_in);
   endtask : beat
   task automatic send(input logic [7:0] b);
      for (int i = 7; i >= 0; i--) beat(b[i]);
   endtask : send
   task automatic hold(input logic h);
      @(negedge sys_clk_in) lane_out[3] <= ~h;
   endtask : hold
endmodule : sfp_host

//--- tb/test_sfp_pin_front.sv
// Self-checking bench for the serial flash pin front end
module test_sfp_pin_front
   import sfp_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   // Arbitrary identifier value
   localparam logic [63:0] UID = 64'h0123_4567_89AB_CDEF;
   logic sys_clk = 1'b0, rst = 1'b1, hw_n = 1'b1, qen = 1'b0, o_st = 1'b0, tx_v = 1'b0;
   logic rx_rdy = 1'b1, busy = 1'b0, susp = 1'b0, resm = 1'b0, cs_n, sclk, rx_v, armed, qref;
   logic [7:0] tx_d = 8'h00, rx_d;
   logic [1:0] er_sel = 2'h0, sec = 2'h0;
   logic [3:0] lane, l_out, l_oe;
   logic [16:0] er_b;
   logic sec_ok;
   logic [63:0] uid;
   logic tx_r, seld, stby, hld, ovr, pgo, sus;
   sfp_width_t width = SFP_W_SINGLE;
   int err_count = 0, comparisons = 0;
   always #12.5 sys_clk = ~sys_clk;
   sfp_host i_sfp_host (.sys_clk_in(sys_clk), .cs_n_out(cs_n), .sclk_out(sclk), .lane_out(lane));
   sfp_pin_front #(.HWRST_CYCLES(4), .UNIQUE_ID(UID)) i_sfp_pin_front (
      .sys_clk_in(sys_clk), .rst_in(rst), .hw_reset_n_in(hw_n), .cs_n_in(cs_n),
      .sclk_in(sclk), .lane_in(lane), .lane_out(l_out), .lane_oe_out(l_oe),
      .quad_lane_enable_in(qen), .width_in(width), .out_start_in(o_st), .tx_data_in(tx_d),
      .tx_valid_in(tx_v), .tx_ready_out(tx_r), .rx_data_out(rx_d), .rx_valid_out(rx_v),
      .rx_ready_in(rx_rdy), .busy_in(busy), .suspend_req_in(susp), .resume_req_in(resm),
      .erase_sel_in(er_sel), .sec_area_in(sec), .selected_out(seld), .standby_out(stby),
      .armed_out(armed), .hold_out(hld), .quad_refused_out(qref), .overrun_out(ovr),
      .page_over_out(pgo), .suspended_out(sus), .erase_bytes_out(er_b),
      .sec_area_ok_out(sec_ok), .unique_id_out(uid));
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : close_out
   task automatic check(input string n, input logic [63:0] e, input logic [63:0] s);
      comparisons++;
      if (e !== s)
      begin
         err_count++;
         $display("BAD %s expected %h seen %h", n, e, s);
      end
   endtask : check
   task automatic t_arm();
      check("lane_oe", 64'h0, l_oe);
      check("uid", UID, uid);
      i_sfp_host.send(8'h5A);
      repeat (4) @(negedge sys_clk);
      check("armed", 64'h0, armed);
      check("rx_valid", 64'h0, rx_v);
      $display("test arm done");
   endtask : t_arm
   task automatic t_write();
      i_sfp_host.sel(1'b0);
      i_sfp_host.sel(1'b1);
      i_sfp_host.send(8'hA5);
      for (int n = 0; n < 200 && rx_v !== 1'b1; n++) @(negedge sys_clk);
      check("rx_valid", 64'h1, rx_v);
      check("rx_data", 64'hA5, rx_d);
      if (rx_v !== 1'b1) close_out();
      check("selected", 64'h1, seld);
      i_sfp_host.hold(1'b1);
      @(negedge sys_clk);
      check("hold", 64'h1, hld);
      i_sfp_host.hold(1'b0);
      rx_rdy <= 1'b0;
      for (int n = 0; n < 255; n++) i_sfp_host.send(8'h00);
      repeat (2) @(negedge sys_clk);
      check("page_over", 64'h0, pgo);
      check("overrun", 64'h1, ovr);
      i_sfp_host.send(8'h00);
      repeat (2) @(negedge sys_clk);
      check("page_over", 64'h1, pgo);
      rx_rdy <= 1'b1;
      $display("test write done");
   endtask : t_write
   task automatic t_read();
      @(negedge sys_clk);
      tx_d <= 8'h3C;
      tx_v <= 1'b1;
      o_st <= 1'b1;
      @(negedge sys_clk);
      tx_v <= 1'b0;
      o_st <= 1'b0;
      check("tx_ready", 64'h0, tx_r);
      for (int i = 7; i >= 0; i--)
      begin
         i_sfp_host.beat(1'b0);
         check("lane_out1", {63'h0, tx_d[i]}, l_out[1]);
      end
      check("lane_oe", 64'h2, l_oe);
      i_sfp_host.sel(1'b0);
      check("lane_oe", 64'h0, l_oe);
      $display("test read done");
   endtask : t_read
   task automatic t_quad();
      i_sfp_host.sel(1'b1);
      width <= SFP_W_DUAL;
      rx_rdy <= 1'b0;
      i_sfp_host.send(8'h0F);
      repeat (2) @(negedge sys_clk);
      check("rx_data", 64'hAA, rx_d);
      rx_rdy <= 1'b1;
      @(negedge sys_clk);
      check("rx_data", 64'h55, rx_d);
      width <= SFP_W_QUAD;
      repeat (3) @(negedge sys_clk);
      check("quad_refused", 64'h1, qref);
      qen <= 1'b1;
      tx_v <= 1'b1;
      o_st <= 1'b1;
      @(negedge sys_clk);
      tx_v <= 1'b0;
      o_st <= 1'b0;
      i_sfp_host.beat(1'b0);
      check("lane_out", 64'h3, l_out);
      check("lane_oe", 64'hF, l_oe);
      check("quad_refused", 64'h0, qref);
      width <= SFP_W_SINGLE;
      qen <= 1'b0;
      i_sfp_host.sel(1'b0);
      $display("test quad done");
   endtask : t_quad
   task automatic t_sel();
      logic [16:0] e;
      for (int k = 0; k < 4; k++)
      begin
         er_sel <= k[1:0];
         sec <= k[1:0];
         busy <= k[0];
         susp <= k[1];
         resm <= ~k[1];
         repeat (3) @(negedge sys_clk);
         e = k == 0 ? SFP_ERASE_4K : k == 1 ? SFP_ERASE_32K : k == 2 ? SFP_ERASE_64K : 17'h0;
         check("erase_bytes", {47'h0, e}, er_b);
         check("sec_ok", {63'h0, k < 3}, sec_ok);
         check("standby", {63'h0, ~k[0]}, stby);
         check("suspended", {63'h0, k == 3}, sus);
      end
      $display("test select done");
   endtask : t_sel
   task automatic t_hwrst();
      hw_n <= 1'b0;
      repeat (8) @(negedge sys_clk);
      hw_n <= 1'b1;
      check("armed", 64'h0, armed);
      check("suspended", 64'h0, sus);
      $display("test hardware reset done");
   endtask : t_hwrst
   initial
   begin
      repeat (5) @(negedge sys_clk);
      rst <= 1'b0;
      @(negedge sys_clk);
      t_arm();
      t_write();
      t_read();
      t_quad();
      t_sel();
      t_hwrst();
      close_out();
   end
endmodule : test_sfp_pin_front
